// ### logic/dio_diag_top.sv
// process-data packing and per-channel diagnostics, apb register slave
//
// Behaviour
// [R1] input variant returns slot-ordered input bytes
// [R2] output variant returns actual output states
// [R3] controller supplies two wanted output bytes
// [R4] mixed: inputs slots 1-4, outputs 5-8
// [R5] mixed: one wanted byte for slots 5-8
// [R6] compare wanted against measured; equal is fine
// [R7] on but measured off: red, error, lock
// [R8] off but measured on: red+yellow, no lock
// [R9] lock the slot outputs that were on
// [R10] locked output off until controller releases
// [R11] settle time after each edge, default 80
// [R12] static channel uses fixed 100 ms filter
// [R13] sensor short: both slot leds red, bit
// [R14] sensor short uses same filter times
// [R15] overload sets error bits, locks slot
// [R16] overload lights active outputs of slot red
// [R17] overload error raises a channel alarm
// [R18] overload uses the shared settle time
// [R19] actuator supply fault: red led, bit
// [R20] supply fault locks every active output
// [R21] supply fault filtered for 300 ms
// [R22] alarms only when reporting is enabled
// [R23] report only after condition held whole time
// [R24] one ms tick, one timer per channel
`timescale 1ns/1ps
module dio_diag_top #(
    parameter int unsigned TICK_CYCLES = dioc_pkg::TICK_CYCLES  // cycles per 1 ms
) (
    input  wire logic        MCLK,          // system clock, 125 MHz
    input  wire logic        RESET_N,       // async reset, active low
    input  wire logic        PSEL,          // apb select
    input  wire logic        PENABLE,       // apb access phase
    input  wire logic        PWRITE,        // apb direction
    input  wire logic [11:0] PADDR,         // apb byte address
    input  wire logic [31:0] PWDATA,        // apb write data
    output logic      [31:0] PRDATA,        // apb read data
    output logic             PREADY,        // apb ready
    output logic             PSLVERR,       // apb error, unmapped address
    input  wire logic [15:0] DIN,           // measured channel states
    input  wire logic [15:0] OVLD,          // driver overload per channel
    input  wire logic [7:0]  SSC,           // sensor supply short per slot
    input  wire logic        UL_FAULT,      // actuator supply out of band
    output logic      [15:0] DOUT,          // output drivers
    output logic      [15:0] LED_RED,       // channel red indicators
    output logic      [15:0] LED_YEL,       // channel yellow indicators
    output logic             LED_UL_RED,    // actuator supply red indicator
    output logic             ALARM          // one-cycle diagnostic alarm
);

    // spread one bit per slot onto both of its channels
    function automatic logic [15:0] slot_spread(input logic [7:0] s);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < dioc_pkg::NUM_SLOT; i++) begin
            r[2*i]   = s[i];
            r[2*i+1] = s[i];
        end
        return r;
    endfunction

    // a slot is flagged if either of its channels is
    function automatic logic [7:0] slot_any(input logic [15:0] c);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < dioc_pkg::NUM_SLOT; i++) begin
            r[i] = c[2*i] | c[2*i+1];
        end
        return r;
    endfunction

    // registers
    dioc_pkg::variant_t variant_reg;        // selected variant
    logic        alarm_en_reg;              // alarm reporting enable
    logic [7:0]  settle_reg;                // settle time, ms
    logic [15:0] wanted_reg;                // wanted bytes, byte n low
    logic [15:0] indata_reg;                // packed process input bytes
    logic [15:0] lock_reg;                  // locked channels
    logic [15:0] err_prev_reg;              // channel errors, previous cycle
    logic [7:0]  ssc_prev_reg;              // sensor errors, previous cycle
    logic        ul_prev_reg;               // supply error, previous cycle

    // combinational nets
    logic        tick;                      // 1 ms pulse
    logic [15:0] out_mask;                  // channels that are outputs
    logic [15:0] wanted_eff;                // wanted state per channel
    logic [15:0] drive_next;                // next driver state
    logic [15:0] ch_edge;                   // driver state is changing
    logic [15:0] ch_cond;                   // raw channel fault
    logic [15:0] ch_err;                    // filtered channel fault
    logic [7:0]  slot_edge;                 // any edge within the slot
    logic [7:0]  ssc_err;                   // filtered sensor short
    logic        ul_err;                    // filtered supply fault
    logic [15:0] lock_rise;                 // new lockable channel errors
    logic [15:0] lock_set;                  // channels to lock now
    logic [15:0] lock_clr;                  // channels released by software
    logic [15:0] lock_next;                 // next lock state
    logic        alarm_next;                // alarm this cycle

    // apb decode
    logic        access;                    // access phase, answer due
    logic        wr_fire;                   // write takes effect
    logic        sel_ctrl;                  // address hits control
    logic        sel_settle;                // address hits settle
    logic        sel_wanted;                // address hits wanted
    logic        sel_lock;                  // address hits lock
    logic        mapped;                    // any register hit
    logic [31:0] rd_mux;                    // read data selection

    assign access     = PSEL & PENABLE;
    assign wr_fire    = access & PREADY & PWRITE;
    assign sel_ctrl   = (PADDR == dioc_pkg::ADDR_CTRL);
    assign sel_settle = (PADDR == dioc_pkg::ADDR_SETTLE);
    assign sel_wanted = (PADDR == dioc_pkg::ADDR_WANTED);
    assign sel_lock   = (PADDR == dioc_pkg::ADDR_LOCK);
    assign mapped     = sel_ctrl | sel_settle | sel_wanted | sel_lock
                      | (PADDR == dioc_pkg::ADDR_INDATA)
                      | (PADDR == dioc_pkg::ADDR_CHERR)
                      | (PADDR == dioc_pkg::ADDR_MODINFO);

    // read mux; unmapped reads return zero with an error
    assign rd_mux =
        sel_ctrl   ? {29'h0, alarm_en_reg, variant_reg} :
        sel_settle ? {24'h0, settle_reg} :
        sel_wanted ? {16'h0, wanted_reg} :
        sel_lock   ? {16'h0, lock_reg} :
        (PADDR == dioc_pkg::ADDR_INDATA)  ? {16'h0, indata_reg} :
        (PADDR == dioc_pkg::ADDR_CHERR)   ? {16'h0, ch_err} :
        (PADDR == dioc_pkg::ADDR_MODINFO) ? {16'h0, ssc_err, 6'h00, ul_err, 1'b0} :
        32'h0000_0000;

    // one wait state: ready rises in the second access cycle so read data
    // can come straight from a flop; costs one cycle per transfer
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= access & ~PREADY;
            PSLVERR <= access & ~PREADY & ~mapped;
            PRDATA  <= (access & ~PREADY & ~PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    // software-writable configuration
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            variant_reg  <= dioc_pkg::CTRL_VAR_RST;
            alarm_en_reg <= dioc_pkg::CTRL_ALARM_RST;
            settle_reg   <= dioc_pkg::SETTLE_RST;                   // [R11]
            wanted_reg   <= dioc_pkg::WANTED_RST;
        end else begin
            if (wr_fire && sel_ctrl) begin
                variant_reg  <= dioc_pkg::variant_t'(PWDATA[dioc_pkg::CTRL_VAR_LSB +: 2]);
                alarm_en_reg <= PWDATA[dioc_pkg::CTRL_ALARM_BIT];
            end
            if (wr_fire && sel_settle) begin
                settle_reg <= PWDATA[7:0];                          // [R11]
            end
            if (wr_fire && sel_wanted) begin
                wanted_reg <= PWDATA[15:0];                         // [R3] [R5]
            end
        end
    end

    // output channels and wanted state per variant; an unused code
    // behaves as the input variant so nothing is ever driven by mistake
    assign out_mask   = (variant_reg == dioc_pkg::VAR_16OUT) ? 16'hffff :
                        (variant_reg == dioc_pkg::VAR_MIXED) ? 16'hff00 : 16'h0000;
    assign wanted_eff = (variant_reg == dioc_pkg::VAR_MIXED)
                      ? {wanted_reg[7:0], 8'h00}                      // [R5]
                      : wanted_reg;                                   // [R3]

    // locked channels are forced off whatever is wanted
    assign drive_next = wanted_eff & out_mask & ~lock_reg;            // [R10]
    assign ch_edge    = drive_next ^ DOUT;                            // [R11]
    assign slot_edge  = slot_any(ch_edge);

    // mismatch between driven and measured state, or driver overload
    assign ch_cond = ((DOUT ^ DIN) | OVLD) & out_mask;               // [R6] [R15]

    ms_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .tick  (tick)                                                 // [R24]
    );

    // one timer per channel and per slot, all sharing the settle setting
    for (genvar c = 0; c < dioc_pkg::NUM_CH; c++) begin : g_ch
        fault_filter u_flt (
            .clk       (MCLK),
            .rst_n     (RESET_N),
            .cond      (ch_cond[c]),                                  // [R23]
            .edge_seen (ch_edge[c]),                                  // [R11]
            .tick      (tick),                                        // [R24]
            .settle_ms (settle_reg),                                  // [R18]
            .static_ms (9'(dioc_pkg::STATIC_FILTER_MS)),              // [R12]
            .fault     (ch_err[c])
        );
    end

    for (genvar s = 0; s < dioc_pkg::NUM_SLOT; s++) begin : g_slot
        fault_filter u_flt (
            .clk       (MCLK),
            .rst_n     (RESET_N),
            .cond      (SSC[s]),                                      // [R13]
            .edge_seen (slot_edge[s]),
            .tick      (tick),
            .settle_ms (settle_reg),                                  // [R14]
            .static_ms (9'(dioc_pkg::STATIC_FILTER_MS)),              // [R14]
            .fault     (ssc_err[s])
        );
    end

    // supply filter never sees an edge, so only the fixed time applies
    fault_filter u_ul_flt (
        .clk       (MCLK),
        .rst_n     (RESET_N),
        .cond      (UL_FAULT),
        .edge_seen (1'b0),
        .tick      (tick),
        .settle_ms (8'h00),
        .static_ms (9'(dioc_pkg::SUPPLY_FILTER_MS)),                  // [R21]
        .fault     (ul_err)
    );

    // newly reported short-circuit or overload errors lock; feedback does not
    assign lock_rise = ch_err & ~err_prev_reg
                     & ((DOUT & ~DIN) | OVLD);                        // [R7] [R8] [R15]
    // lock every channel of the slot that is on at that moment
    assign lock_set  = (slot_spread(slot_any(lock_rise)) & DOUT)      // [R9]
                     | ((ul_err & ~ul_prev_reg) ? DOUT : 16'h0000);   // [R20]
    assign lock_clr  = (wr_fire && sel_lock) ? PWDATA[15:0] : 16'h0000;
    // a new lock in the release cycle wins over the release
    assign lock_next = (lock_reg & ~lock_clr) | lock_set;             // [R10]

    // alarm on incoming and outgoing events, only when enabled
    assign alarm_next = alarm_en_reg                                  // [R22]
                      & ((|(ch_err ^ err_prev_reg))                   // [R17]
                      |  (|(ssc_err ^ ssc_prev_reg))
                      |  (ul_err ^ ul_prev_reg));

    // diagnostic state and pins
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lock_reg     <= 16'h0000;
            err_prev_reg <= 16'h0000;
            ssc_prev_reg <= 8'h00;
            ul_prev_reg  <= 1'b0;
            indata_reg   <= 16'h0000;
            DOUT         <= 16'h0000;
            LED_RED      <= 16'h0000;
            LED_YEL      <= 16'h0000;
            LED_UL_RED   <= 1'b0;
            ALARM        <= 1'b0;
        end else begin
            lock_reg     <= lock_next;                                // [R7] [R9]
            err_prev_reg <= ch_err;
            ssc_prev_reg <= ssc_err;
            ul_prev_reg  <= ul_err;
            // measured states already sit in slot order, A even, B odd
            indata_reg   <= DIN;                                      // [R1] [R2] [R4]
            DOUT         <= drive_next;                               // [R10]
            LED_RED      <= (ch_err & out_mask)                       // [R7] [R8]
                          | slot_spread(ssc_err)                      // [R13]
                          | (slot_spread(slot_any(ch_err & OVLD)) & DOUT); // [R16]
            LED_YEL      <= ch_err & ~DOUT & DIN;                     // [R8]
            LED_UL_RED   <= ul_err;                                   // [R19]
            ALARM        <= alarm_next;
        end
    end

endmodule // dio_diag_top

// ### logic/dioc_pkg.sv
// shared constants, register map and types for the digital i/o diagnostics block
package dioc_pkg;

    // module variant, selected by software in the control register
    typedef enum logic [1:0] {
        VAR_16IN  = 2'h0,                    // sixteen inputs
        VAR_16OUT = 2'h1,                    // sixteen outputs
        VAR_MIXED = 2'h2                     // slots 1..4 inputs, slots 5..8 outputs
    } variant_t;

    localparam int NUM_CH   = 16;            // channels, two per slot
    localparam int NUM_SLOT = 8;             // connector slots

    // register byte addresses (one aligned 32-bit word each)
    localparam logic [11:0] ADDR_CTRL    = 12'h000;  // variant and alarm enable
    localparam logic [11:0] ADDR_SETTLE  = 12'h004;  // settle time in ms
    localparam logic [11:0] ADDR_WANTED  = 12'h008;  // wanted output bytes
    localparam logic [11:0] ADDR_INDATA  = 12'h00c;  // process input bytes
    localparam logic [11:0] ADDR_CHERR   = 12'h010;  // filtered channel errors
    localparam logic [11:0] ADDR_LOCK    = 12'h014;  // locked channels, write 1 releases
    localparam logic [11:0] ADDR_MODINFO = 12'h018;  // module information

    // field positions
    localparam int CTRL_VAR_LSB     = 0;     // variant, two bits
    localparam int CTRL_ALARM_BIT   = 2;     // alarm reporting enable
    localparam int MODINFO_UL_BIT   = 1;     // actuator undervoltage
    localparam int MODINFO_SSC_LSB  = 8;     // sensor short, one bit per slot

    // reset values
    localparam variant_t    CTRL_VAR_RST   = VAR_16IN;
    localparam logic        CTRL_ALARM_RST = 1'b0;
    localparam logic [7:0]  SETTLE_RST     = 8'h50;  // 80 ms
    localparam logic [15:0] WANTED_RST     = 16'h0000;

    // timing
    localparam int CLK_PERIOD_NS    = 8;         // 125 MHz
    localparam int TICK_PERIOD_NS   = 1000000;   // 1 ms
    localparam int TICK_CYCLES      = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int STATIC_FILTER_MS = 100;       // filter while channel is static
    localparam int SUPPLY_FILTER_MS = 300;       // actuator supply filter

endpackage

// ### logic/ms_tick.sv
// one-millisecond tick generator from the system clock
`timescale 1ns/1ps
module ms_tick #(
    parameter int unsigned TICK_CYCLES = 125000   // clock cycles per tick
) (
    input  wire logic clk,                       // system clock
    input  wire logic rst_n,                     // async reset, active low
    output logic      tick                       // one-cycle pulse each period
);

    logic [31:0] cnt_reg;                        // cycles since last tick
    logic        wrap;                           // last cycle of period

    assign wrap = (cnt_reg == 32'(TICK_CYCLES - 1));

    // free-running divider; tick is registered to keep it glitch free
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 32'h0;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= wrap ? 32'h0 : cnt_reg + 32'h1;
            tick    <= wrap;
        end
    end

endmodule // ms_tick

// ### logic/fault_filter.sv
// per-channel fault filter: condition must persist for the applicable time
`timescale 1ns/1ps
module fault_filter (
    input  wire logic       clk,                 // system clock
    input  wire logic       rst_n,               // async reset, active low
    input  wire logic       cond,                // raw fault condition
    input  wire logic       edge_seen,           // output state just changed
    input  wire logic       tick,                // 1 ms pulse
    input  wire logic [7:0] settle_ms,           // time after an edge
    input  wire logic [8:0] static_ms,           // time while static
    output logic            fault                // filtered fault
);

    logic [8:0] cnt_reg;                         // ms the condition has held
    logic       transient_reg;                   // edge seen, condition never cleared
    logic [8:0] limit;                           // applicable filter time
    logic       reached;                         // held long enough

    assign limit   = transient_reg ? {1'b0, settle_ms} : static_ms;
    assign reached = (cnt_reg >= limit);

    // timer restarts on every edge and whenever the condition drops;
    // counter saturates at the limit so it can never wrap into a false pass
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg       <= 9'h000;
            transient_reg <= 1'b0;
            fault         <= 1'b0;
        end else if (edge_seen) begin        // suppress after an edge
            cnt_reg       <= 9'h000;
            transient_reg <= 1'b1;
            fault         <= 1'b0;
        end else if (!cond) begin            // condition gone: restart, go static
            cnt_reg       <= 9'h000;
            transient_reg <= 1'b0;
            fault         <= 1'b0;
        end else begin                       // condition held: count on
            if (tick && !reached) begin
                cnt_reg <= cnt_reg + 9'h001;
            end
            fault <= reached;
        end
    end

endmodule // fault_filter

// ### test/dio_diag_monitor.sv
// port checker for the digital i/o diagnostics block
`timescale 1ns/1ps
module dio_diag_monitor #(
    parameter int unsigned TICK_CYCLES = 125000   // cycles per 1 ms
) (
    input logic        MCLK,        // system clock
    input logic        RESET_N,     // async reset, active low
    input logic        PSEL,        // apb select
    input logic        PENABLE,     // apb access phase
    input logic [31:0] PRDATA,      // apb read data
    input logic        PREADY,      // apb ready
    input logic        PSLVERR,     // apb error
    input logic        UL_FAULT,    // actuator supply fault
    input logic [15:0] DOUT,        // output drivers
    input logic [15:0] LED_RED,     // red indicators
    input logic [15:0] LED_YEL,     // yellow indicators
    input logic        LED_UL_RED,  // supply indicator
    input logic        ALARM        // alarm pulse
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    int ul_cnt;  // supply fault run length

    // restarts whenever the fault drops
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) ul_cnt <= 0;
        else ul_cnt <= UL_FAULT ? ul_cnt + 1 : 0;
    end

    a_ready_wait: assert property ((PSEL && !PENABLE) ##1 (PSEL && PENABLE) |=> PREADY)
        else $error("ready missing in second access cycle");
    a_ready_once: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_idle_data: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside ready cycle");
    a_err_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
        else $error("error outside a transfer");
    a_yel_red: assert property ((LED_YEL & ~LED_RED) == 16'h0)
        else $error("yellow without red");
    a_ul_filter: assert property ($rose(LED_UL_RED) |->
        ul_cnt >= (dioc_pkg::SUPPLY_FILTER_MS - 1) * TICK_CYCLES)
        else $error("supply fault reported too early");
    a_ul_clear: assert property (!UL_FAULT [*4] |-> !LED_UL_RED)
        else $error("supply led without fault");
    a_ul_lock: assert property ($rose(LED_UL_RED) |-> ##[0:4] DOUT == 16'h0)
        else $error("outputs not locked on supply fault");

    // main scenarios reached
    c_slverr: cover property (PREADY && PSLVERR);
    c_ul: cover property ($rose(LED_UL_RED));
    c_yel: cover property (|LED_YEL);
    c_alarm: cover property (ALARM);
endmodule // dio_diag_monitor

bind dio_diag_top dio_diag_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.MCLK(MCLK),
    .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .UL_FAULT(UL_FAULT), .DOUT(DOUT), .LED_RED(LED_RED),
    .LED_YEL(LED_YEL), .LED_UL_RED(LED_UL_RED), .ALARM(ALARM));

// ### test/field_model.sv
// field-side model: output monitors loop back, faults injected on command
`timescale 1ns/1ps
module field_model (
    input  logic [15:0] dout,     // output drivers of the block
    input  logic [15:0] short_m,  // channels pulled low by a short
    input  logic [15:0] feed_m,   // channels fed back from outside
    input  logic [15:0] in_val,   // sensor states on input channels
    output logic [15:0] din       // measured channel states
);
    // a shorted driver reads off, an outside source reads on
    assign din = (dout & ~short_m) | feed_m | in_val;
endmodule // field_model

// ### test/tb_dio_diag_top.sv
// self-checking bench for the digital i/o diagnostics block
`timescale 1ns/1ps
module tb_dio_diag_top;
    logic        mclk, reset_n, psel, penable, pwrite, ul_fault, pready, pslverr, alarm, ul_led, e;
    logic [11:0] paddr;                                          // apb address
    logic [31:0] pwdata, prdata, rv;                             // apb data, last read
    logic [15:0] din, ovld, dout, led_red, led_yel, short_m, feed_m, in_val;
    logic [7:0]  ssc;                                            // sensor shorts
    int          error_cnt = 0, num_checks = 0, alarm_cnt = 0, n, a;

    // ten cycles a ms keeps filter times short
    dio_diag_top #(.TICK_CYCLES(10)) u_dut (.MCLK(mclk), .RESET_N(reset_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .DIN(din), .OVLD(ovld), .SSC(ssc),
        .UL_FAULT(ul_fault), .DOUT(dout), .LED_RED(led_red), .LED_YEL(led_yel),
        .LED_UL_RED(ul_led), .ALARM(alarm));
    field_model u_field (.dout(dout), .short_m(short_m), .feed_m(feed_m), .in_val(in_val),
        .din(din));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // alarm pulses, compared before and after
    always @(posedge mclk) if (alarm === 1'b1) alarm_cnt <= alarm_cnt + 1;

    // one apb transfer, held until ready is seen
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rv = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge mclk);
    endtask
    task chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task rd(input logic [11:0] ad, input logic [31:0] x);
        apb(1'b0, ad, 32'h0);
        chk(rv, x);
    endtask
    task wr(input logic [11:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask
    task cyc(input int c);
        repeat (c) @(negedge mclk);
    endtask
    // wait for an indicator: 0..15 red, 16..31 yellow, 32 supply; cycles in n
    task wt(input int k);
        n = 0;
        while (!(k < 16 ? led_red[k] : k < 32 ? led_yel[k-16] : ul_led) && n < 4000) begin
            @(negedge mclk);
            n++;
        end
    endtask
    task win(input int lo, input int hi);
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask
    task fin(input string s);
        $display("test %s done, mismatches %0d", s, error_cnt);
    endtask

    task t_reset;
        rd(dioc_pkg::ADDR_CTRL, 32'h0);
        rd(dioc_pkg::ADDR_SETTLE, 32'h50);
        rd(dioc_pkg::ADDR_LOCK, 32'h0);
        apb(1'b0, 12'h01c, 32'h0); // unmapped word
        chk(32'(e), 32'h1);
        chk(rv, 32'h0);
    endtask
    task t_io;
        @(posedge mclk);
        in_val <= 16'hc3a5;
        wr(dioc_pkg::ADDR_WANTED, 32'h00a5);
        rd(dioc_pkg::ADDR_INDATA, 32'hc3a5);
        chk(32'(dout), 32'h0);
        @(posedge mclk);
        in_val <= 16'h003c;
        wr(dioc_pkg::ADDR_CTRL, 32'h2);
        cyc(3);
        chk(32'(dout), 32'ha500);
        rd(dioc_pkg::ADDR_INDATA, 32'ha53c);
    endtask
    // short on a static channel locks the whole active slot
    task t_short;
        @(posedge mclk);
        in_val <= 16'h0;
        wr(dioc_pkg::ADDR_CTRL, 32'h5);
        wr(dioc_pkg::ADDR_WANTED, 32'h3);
        cyc(1000);
        rd(dioc_pkg::ADDR_INDATA, 32'h3);
        rd(dioc_pkg::ADDR_CHERR, 32'h0);
        @(posedge mclk);
        short_m <= 16'h0001;
        wt(0);
        win(985, 1015);
        cyc(4);
        chk(32'(dout), 32'h0);
        rd(dioc_pkg::ADDR_LOCK, 32'h3);
        @(posedge mclk);
        short_m <= 16'h0;
        cyc(20);
        chk(32'(dout), 32'h0);
        wr(dioc_pkg::ADDR_LOCK, 32'h3);
        cyc(3);
        chk(32'(dout), 32'h3);
    endtask
    // after an edge the settle time applies; a lone output locks alone
    task t_settle;
        wr(dioc_pkg::ADDR_SETTLE, 32'h14);
        @(posedge mclk);
        short_m <= 16'h0040;
        wr(dioc_pkg::ADDR_WANTED, 32'h43);
        wt(6);
        win(185, 225);
        cyc(4);
        rd(dioc_pkg::ADDR_LOCK, 32'h40);
        @(posedge mclk);
        short_m <= 16'h0;
        wr(dioc_pkg::ADDR_LOCK, 32'h40);
    endtask
    // feedback with alarms off: red and yellow, no lock, no alarm
    task t_feed;
        wr(dioc_pkg::ADDR_CTRL, 32'h1);
        a = alarm_cnt;
        @(posedge mclk);
        feed_m <= 16'h0010;
        wt(20);
        chk(32'(led_red[4]), 32'h1);
        chk(alarm_cnt - a, 32'h0);
        @(posedge mclk);
        feed_m <= 16'h0;
        cyc(5);
        rd(dioc_pkg::ADDR_LOCK, 32'h0);
    endtask
    task t_ovld;
        wr(dioc_pkg::ADDR_CTRL, 32'h5);
        wr(dioc_pkg::ADDR_WANTED, 32'h0343);
        cyc(300);
        a = alarm_cnt;
        @(posedge mclk);
        ovld <= 16'h0100;
        wt(9);
        chk(32'(led_red[8]), 32'h1);
        cyc(4);
        chk(32'(alarm_cnt != a), 32'h1);
        rd(dioc_pkg::ADDR_LOCK, 32'h300);
        @(posedge mclk);
        ovld <= 16'h0;
        wr(dioc_pkg::ADDR_LOCK, 32'h300);
    endtask
    task t_ssc;
        @(posedge mclk);
        ssc <= 8'h04;
        wt(5);
        win(985, 1015);
        chk(32'(led_red[5:4]), 32'h3);
        rd(dioc_pkg::ADDR_MODINFO, 32'h400);
        @(posedge mclk);
        ssc <= 8'h0;
    endtask
    task t_ul;
        cyc(20);
        @(posedge mclk);
        ul_fault <= 1'b1;
        wt(32);
        win(2985, 3015);
        cyc(4);
        chk(32'(dout), 32'h0);
        rd(dioc_pkg::ADDR_MODINFO, 32'h2);
        @(posedge mclk);
        ul_fault <= 1'b0;
        cyc(5);
        chk(32'(ul_led), 32'h0);
    endtask

    task results;
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // watchdog, about six times the expected run
    initial begin
        #400000;
        error_cnt++;
        results;
    end
    initial begin
        {reset_n, psel, penable, pwrite, ul_fault} = 5'h0;
        {paddr, pwdata, ovld, short_m, feed_m, in_val, ssc} = '0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset;
        fin("reset");
        t_io;
        fin("packing");
        t_short;
        fin("short");
        t_settle;
        fin("settle");
        t_feed;
        fin("feedback");
        t_ovld;
        fin("overload");
        t_ssc;
        fin("sensor");
        t_ul;
        fin("supply");
        results;
    end
endmodule // tb_dio_diag_top
